// File: rtl/auto_flow_control.sv
`timescale 1ns/100ps
`include "flow_ctl_defs.svh"


module auto_flow_control #(
  parameter int FILL_W = 14
) (
  input  wire logic                   core_clk_i,
  input  wire logic                   arst_n_i,
  input  wire logic [7:0]             reg_addr_i,
  input  wire logic [31:0]            reg_wdata_i,
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  output logic [31:0]                 reg_rdata_o,
  input  wire logic [FILL_W-1:0]      rx_fifo_fill_i,
  input  wire logic                   full_duplex_i,
  input  wire logic                   speed_100_i,
  input  wire logic                   tx_enable_i,
  input  wire flow_ctl_pkg::rx_event_t rx_event_i,
  input  wire logic [15:0]            pause_time_value_i,
  input  wire logic                   pause_ack_i,
  output logic                        pause_req_o,
  output logic [15:0]                 pause_time_o,
  output logic                        jam_o
);

  import flow_ctl_pkg::*;

  // =====================================================================
  // configuration register
  logic [31:0] cfg_reg;
  cfg_t        cfg;

  assign cfg = cfg_t'(cfg_reg[23:0]);

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_reg <= `CFG_RESET;
    end else if (reg_wr_i && reg_addr_i == `CFG_ADDR) begin
      cfg_reg <= reg_wdata_i & `CFG_WRITE_MASK;
    end
  end

  // =====================================================================
  // threshold compare, units of 64 bytes
  function automatic logic [FILL_W-1:0] to_bytes(input logic [7:0] lvl);
    return FILL_W'({lvl, 6'h00});
  endfunction

  logic at_high;
  logic below_low;
  logic enabled;

  assign at_high   = rx_fifo_fill_i >= to_bytes(cfg.flow_high_threshold);
  assign below_low = rx_fifo_fill_i <  to_bytes(cfg.flow_low_threshold);
  // full duplex is enabled by any-frame; half duplex by any-frame or any class bit
  assign enabled   = cfg.flow_on_any_frame |
                     (!full_duplex_i & (cfg.flow_on_multicast | cfg.flow_on_broadcast |
                                        cfg.flow_on_own_address));

  // =====================================================================
  // full duplex pause sequencing
  fd_state_t fd_state_reg;
  logic      pause_req_reg;
  logic      pause_zero_reg;
  logic      fd_active;

  assign fd_active = full_duplex_i & cfg.flow_on_any_frame & tx_enable_i;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fd_state_reg   <= ST_IDLE;
      pause_req_reg  <= 1'b0;
      pause_zero_reg <= 1'b0;
    end else if (!fd_active) begin
      // a queued request is withdrawn when the transmitter stops
      fd_state_reg   <= ST_IDLE;
      pause_req_reg  <= 1'b0;
      pause_zero_reg <= 1'b0;
    end else begin
      case (fd_state_reg)
        ST_IDLE: begin
          if (at_high) begin
            pause_req_reg  <= 1'b1;
            pause_zero_reg <= 1'b0;
            fd_state_reg   <= ST_ABOVE;
          end
        end
        ST_ABOVE: begin
          if (pause_req_reg && pause_ack_i) begin
            pause_req_reg <= 1'b0;
            fd_state_reg  <= ST_PAUSED;
          end
        end
        ST_PAUSED: begin
          if (below_low && !pause_req_reg) begin
            pause_req_reg  <= 1'b1;
            pause_zero_reg <= 1'b1;
          end else if (pause_req_reg && pause_ack_i) begin
            pause_req_reg  <= 1'b0;
            pause_zero_reg <= 1'b0;
            fd_state_reg   <= ST_IDLE;
          end
        end
        default: begin
          fd_state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  assign pause_req_o = pause_req_reg;

  // pause time frozen while a request is pending; zero for the resume frame
  logic [15:0] pause_time_reg;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pause_time_reg <= 16'h0000;
    end else if (fd_active && fd_state_reg == ST_PAUSED && below_low && !pause_req_reg) begin
      pause_time_reg <= 16'h0000;
    end else if (!pause_req_reg) begin
      pause_time_reg <= pause_time_value_i;
    end
  end

  assign pause_time_o = pause_time_reg;

  // =====================================================================
  // half duplex backpressure
  logic hd_active;
  logic class_match;
  logic jam_load;
  logic jam_active;

  assign hd_active = !full_duplex_i & tx_enable_i & at_high;

  always_comb begin
    class_match = 1'b0;
    if (cfg.flow_on_any_frame) begin
      class_match = rx_event_i.preamble;
    end else if (rx_event_i.addr_valid) begin
      class_match = (cfg.flow_on_multicast   & rx_event_i.multicast)   |
                    (cfg.flow_on_broadcast   & rx_event_i.broadcast)   |
                    (cfg.flow_on_own_address & rx_event_i.own_address);
    end
  end

  assign jam_load = hd_active & class_match;

  jam_timer #(
    .DUR_W (`DUR_W)
  ) u_jam_timer (
    .core_clk_i  (core_clk_i),
    .arst_n_i    (arst_n_i),
    .load_i      (jam_load),
    .code_i      (cfg.jam_duration_code),
    .speed_100_i (speed_100_i),
    .abort_i     (full_duplex_i | !tx_enable_i),
    .active_o    (jam_active)
  );

  assign jam_o = jam_active;

  // =====================================================================
  // register read
  logic [31:0] rdata_reg;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      if (reg_addr_i == `CFG_ADDR) begin
        rdata_reg <= cfg_reg;
      end else if (reg_addr_i == `STATUS_ADDR) begin
        rdata_reg <= {24'h00_0000, 1'b0, jam_active, pause_zero_reg, pause_req_reg,
                      enabled, at_high, fd_state_reg};
      end else begin
        rdata_reg <= 32'h0000_0000;
      end
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  assign reg_rdata_o = rdata_reg;

endmodule

// File: shared/flow_ctl_defs.svh
`ifndef FLOW_CTL_DEFS_SVH
`define FLOW_CTL_DEFS_SVH

// =====================================================================
// register map
`define CFG_ADDR            8'hac
`define CFG_ADDR_W          8
`define CFG_RESET           32'h0000_0000
`define CFG_WRITE_MASK      32'h00ff_ffff
`define STATUS_ADDR         8'hb4
`define HI_MSB              23
`define HI_LSB              16
`define LO_MSB              15
`define LO_LSB              8
`define DUR_MSB             7
`define DUR_LSB             4
`define BIT_MULTICAST       3
`define BIT_BROADCAST       2
`define BIT_OWN_ADDR        1
`define BIT_ANY_FRAME       0

// =====================================================================
// timing
`define CLK_MHZ             125
`define DUR_10M_EXTRA_NS    2200
`define DUR_W               17

`endif

// File: shared/flow_ctl_pkg.sv
package flow_ctl_pkg;

  // receive-side frame event from the mac
  typedef struct packed {
    logic preamble;
    logic addr_valid;
    logic multicast;
    logic broadcast;
    logic own_address;
  } rx_event_t;

  typedef struct packed {
    logic [7:0] flow_high_threshold;
    logic [7:0] flow_low_threshold;
    logic [3:0] jam_duration_code;
    logic       flow_on_multicast;
    logic       flow_on_broadcast;
    logic       flow_on_own_address;
    logic       flow_on_any_frame;
  } cfg_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ABOVE,
    ST_PAUSED
  } fd_state_t;

endpackage

// File: rtl/jam_timer.sv
`timescale 1ns/100ps
`include "flow_ctl_defs.svh"

module jam_timer #(
  parameter int DUR_W = `DUR_W
) (
  input  wire logic             core_clk_i,
  input  wire logic             arst_n_i,
  input  wire logic             load_i,
  input  wire logic [3:0]       code_i,
  input  wire logic             speed_100_i,
  input  wire logic             abort_i,
  output logic                  active_o
);

  logic [DUR_W-1:0] count_reg;

  // duration in us: 5,10,15,25,50 then 50 us steps
  function automatic logic [DUR_W-1:0] dur_cycles(input logic [3:0] c, input logic fast);
    int unsigned us;
    int unsigned ns;
    us = 0;
    case (c)
      4'h0: us = 5;
      4'h1: us = 10;
      4'h2: us = 15;
      4'h3: us = 25;
      default: us = (int'(c) - 3) * 50;
    endcase
    ns = us * 1000 + (fast ? 0 : `DUR_10M_EXTRA_NS);
    return DUR_W'((ns * `CLK_MHZ) / 1000);
  endfunction

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count_reg <= '0;
    end else if (abort_i) begin
      count_reg <= '0;
    end else if (load_i) begin
      count_reg <= dur_cycles(code_i, speed_100_i);
    end else if (count_reg != '0) begin
      count_reg <= count_reg - DUR_W'(1);
    end
  end

  assign active_o = (count_reg != '0);

endmodule

// File: dv/auto_flow_control_asserts.sv
`timescale 1ns/100ps
module auto_flow_control_asserts
  import flow_ctl_pkg::*;
(
  input wire logic core_clk_i, arst_n_i, full_duplex_i, tx_enable_i,
  input wire logic pause_ack_i, pause_req_o, jam_o,
  input wire logic [15:0] pause_time_value_i, pause_time_o,
  input wire flow_ctl_pkg::rx_event_t rx_event_i
);
  // ==========
  // checks
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_acked;
    pause_req_o && pause_ack_i;
  endsequence
  sequence s_jam_run;
    $rose(jam_o) ##0 (tx_enable_i && !full_duplex_i)[*8];
  endsequence
  chk_ack_drops: assert property (s_acked |=> !pause_req_o)
    else $error("pause request kept after ack");
  chk_req_holds: assert property (pause_req_o && !pause_ack_i && tx_enable_i &&
    full_duplex_i |=> pause_req_o) else $error("pause request dropped early");
  chk_req_mode: assert property ($rose(pause_req_o) |->
    $past(full_duplex_i && tx_enable_i)) else $error("pause outside enabled full duplex");
  chk_pause_time: assert property ($rose(pause_req_o) && pause_time_o != 16'h0 |->
    pause_time_o == pause_time_value_i) else $error("wrong pause time");
  chk_tx_off: assert property (!tx_enable_i |=> !jam_o && !pause_req_o)
    else $error("flow control with transmitter off");
  chk_fd_no_jam: assert property (full_duplex_i |=> !jam_o)
    else $error("jam in full duplex");
  chk_jam_cause: assert property ($rose(jam_o) |->
    $past(rx_event_i.preamble || rx_event_i.addr_valid)) else $error("jam without frame");
  chk_jam_min: assert property (s_jam_run |-> jam_o)
    else $error("jam too short");
endmodule

// File: dv/mac_partner.sv
`timescale 1ns/100ps
module mac_partner (
  input  wire logic       core_clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       req_i,
  input  wire logic [3:0] delay_i,
  output logic            ack_o
);
  logic [3:0] cnt_reg;
  // ==========
  // ack a pending pause delay_i+1 cycles after it is seen, as a transmit window opens
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_reg <= 4'h0;
      ack_o <= 1'b0;
    end else begin
      ack_o <= 1'b0;
      if (!req_i || ack_o) cnt_reg <= 4'h0;
      else if (cnt_reg == delay_i) ack_o <= 1'b1;
      else cnt_reg <= cnt_reg + 4'h1;
    end
  end
endmodule

// File: dv/test_auto_flow_control.sv
`timescale 1ns/100ps
module test_auto_flow_control;
  import flow_ctl_pkg::*;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, fd = 1, spd = 1, txe = 1, ack, req, jam;
  logic [7:0] addr = '0;
  logic [31:0] wd = '0, rdata;
  logic [13:0] fill = '0;
  logic [15:0] pt;
  logic [3:0] dly = 4'h2;
  rx_event_t ev = '0;
  int fail_count = 0, samples_checked = 0, n;
  always #4 clk = ~clk;
  auto_flow_control i_dut (.core_clk_i(clk), .arst_n_i(rst_n), .reg_addr_i(addr),
    .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .rx_fifo_fill_i(fill), .full_duplex_i(fd), .speed_100_i(spd), .tx_enable_i(txe),
    .rx_event_i(ev), .pause_time_value_i(16'h1234), .pause_ack_i(ack),
    .pause_req_o(req), .pause_time_o(pt), .jam_o(jam));
  mac_partner i_mac (.core_clk_i(clk), .arst_n_i(rst_n), .req_i(req), .delay_i(dly),
    .ack_o(ack));
  // ==========
  // tasks
  task automatic wrap_up;
    $display("checked=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk); addr <= a; wd <= d; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    @(negedge clk); cmp(rdata, e);
  endtask
  task automatic wreq(input logic v);
    n = 0;
    while (req !== v && n < 100) begin @(negedge clk); n++; end
    if (n == 100) begin fail_count++; wrap_up(); end
  endtask
  task automatic idle_req;
    repeat (20) @(negedge clk);
    cmp(req, 0);
  endtask
  task automatic pulse(input rx_event_t v);
    @(posedge clk); ev <= v;
    @(posedge clk); ev <= '0;
  endtask
  task automatic jam_len(input int e);
    n = 0;
    @(negedge clk);
    while (jam === 1'b1 && n < 2000) begin n++; @(negedge clk); end
    cmp(n, e);
  endtask
  // ==========
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rreg(8'hac, 0);
    wreg(8'hac, 32'hffffffff);
    rreg(8'hac, 32'h00ffffff);
    rreg(8'h10, 0);
    wreg(8'hac, 32'h00040201);
    fill <= 14'd255; idle_req();
    fill <= 14'd256; wreq(1); cmp(pt, 16'h1234);
    wreq(0); idle_req();
    dly <= 4'hb; fill <= 14'd127; wreq(1); cmp(pt, 0);
    wreq(0); fill <= 14'd200; idle_req();
    fill <= 14'd100; idle_req();
    rreg(8'hb4, 32'h0000_0008);
    wreg(8'hac, 32'h0004020e); fill <= 14'd300; idle_req();
    fd <= 1'b0;
    wreg(8'hac, 32'h00040201);
    for (int s = 0; s < 2; s++) begin
      spd <= s[0]; pulse(5'h10); jam_len(s ? 625 : 900);
    end
    pulse(5'h10); repeat (100) @(negedge clk);
    pulse(5'h10); jam_len(625);
    pulse(5'h10); repeat (5) @(posedge clk);
    txe <= 1'b0; jam_len(1);
    txe <= 1'b1;
    for (int i = 1; i < 4; i++) begin
      wreg(8'hac, 32'h00040200 | (1 << i));
      pulse(5'h08 | (5'h1 << (i % 3))); jam_len(0);
      pulse(5'h08 | (5'h1 << (i - 1))); jam_len(625);
    end
    wreg(8'hac, 32'h00040201);
    fd <= 1'b1; txe <= 1'b0; idle_req();
    txe <= 1'b1; wreq(1); cmp(pt, 16'h1234);
    wreq(0);
    wrap_up();
  end
endmodule
bind auto_flow_control auto_flow_control_asserts i_chk (.core_clk_i, .arst_n_i,
  .full_duplex_i, .tx_enable_i, .pause_ack_i, .pause_req_o, .jam_o, .pause_time_value_i,
  .pause_time_o, .rx_event_i);
